//--- design/isbt_top.sv
// settings store, unit conversion, key lock and timed bcd output
`timescale 1ns/100ps
`default_nettype none
module isbt_top
  import isbt_pkg::*;
#(
  parameter int TICK_N = TICK_CYC // clock cycles in one millisecond
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [3:0]  key_in,
  input  wire logic [16:0] weight_kg,
  input  wire logic        weight_neg,
  input  wire logic        cal_req,
  input  wire logic [16:0] cal_value,
  output logic      [3:0]  key_act,
  output logic      [19:0] bcd_n,
  output logic             pol_out,
  output logic             busy_n,
  output logic      [16:0] cal_store
);
  // register offsets of the plain port
  localparam logic [2:0] A_UNIT = 3'h0;
  localparam logic [2:0] A_KEYS = 3'h1;
  localparam logic [2:0] A_PER  = 3'h2;
  localparam logic [2:0] A_CMD  = 3'h3;
  localparam logic [2:0] A_STAT = 3'h4;
  localparam logic [2:0] A_CAL  = 3'h5;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic       rs1_q;
  logic       rst_n;
  logic [3:0] k1_q;
  logic [3:0] k2_q;
  logic [3:0] k3_q;
  logic       c1_q;
  logic       c2_q;

  // reset enters asynchronously, is released on clock edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // front keys and calibration request come from outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k1_q <= 4'h0;
      k2_q <= 4'h0;
      k3_q <= 4'h0;
      c1_q <= 1'b0;
      c2_q <= 1'b0;
    end else begin
      k1_q <= key_in;
      k2_q <= k1_q;
      k3_q <= k2_q;
      c1_q <= cal_req;
      c2_q <= c1_q;
    end
  end

  // ------------------------------------------------------------
  // settings, saved image, lock
  // ------------------------------------------------------------
  isbt_set_t act_q;
  isbt_set_t save_q;
  logic      lock_q;
  logic      refused_q;
  logic      c3_q;
  logic [16:0] cal_q;
  logic      wr_unit;
  logic      wr_keys;
  logic      wr_per;
  logic      wr_cmd;
  logic      do_backup;
  logic      do_restore;
  logic      cmd_blocked;
  logic      cal_rise;
  logic      per_ok;

  assign wr_unit = wr && addr == A_UNIT && wdata <= 16'(UNIT_MPA);
  assign wr_keys = wr && addr == A_KEYS;
  // only the seven listed periods are accepted
  assign per_ok  = wdata <= 16'(PER_1000);
  assign wr_per  = wr && addr == A_PER && per_ok;
  assign wr_cmd  = wr && addr == A_CMD;
  // backup and restore refused while locked
  assign cmd_blocked = lock_q && (wdata[0] || wdata[1] || c2_q);
  assign do_backup   = wr_cmd && wdata[0] && !lock_q;
  assign do_restore  = wr_cmd && wdata[1] && !wdata[0] && !lock_q;
  assign cal_rise    = c2_q && !c3_q;

  // active settings; restore loads the saved image
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= SET_RST;
    end else if (do_restore) begin
      act_q <= save_q;
    end else begin
      if (wr_unit) act_q.unit <= wdata[2:0];
      if (wr_keys) act_q.keymask <= wdata[3:0];
      if (wr_per) act_q.period <= wdata[2:0];
    end
  end

  // backup copies without touching the active set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      save_q <= SET_RST;
    end else if (do_backup) begin
      save_q <= act_q;
    end
  end

  // lock bit, sticky refusal flag; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q    <= 1'b0;
      refused_q <= 1'b0;
      c3_q      <= 1'b0;
      cal_q     <= 17'h0;
    end else begin
      c3_q <= c2_q;
      if (wr_cmd) lock_q <= wdata[2];
      if ((wr_cmd && cmd_blocked) || (cal_rise && lock_q))
        refused_q <= 1'b1;
      else if (wr_cmd && wdata[3])
        refused_q <= 1'b0;
      // calibration kept raw in kilograms
      if (cal_rise && !lock_q) cal_q <= cal_value;
    end
  end

  // ------------------------------------------------------------
  // key masking
  // ------------------------------------------------------------
  logic [3:0] key_act_q;
  // set mask bit suppresses the key, bit 0 is hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) key_act_q <= 4'h0;
    else key_act_q <= k2_q & ~k3_q & ~act_q.keymask;
  end

  // ------------------------------------------------------------
  // millisecond tick and period counter
  // ------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic        tick;
  logic [9:0]  ms_q;
  logic [9:0]  per_ms;
  logic        frame;

  function automatic logic [9:0] per_to_ms(input logic [2:0] p);
    case (p)
      PER_10:   per_to_ms = 10'd10;
      PER_20:   per_to_ms = 10'd20;
      PER_50:   per_to_ms = 10'd50;
      PER_100:  per_to_ms = 10'd100;
      PER_200:  per_to_ms = 10'd200;
      PER_500:  per_to_ms = 10'd500;
      PER_1000: per_to_ms = 10'd1000;
      default:  per_to_ms = 10'd100;
    endcase
  endfunction

  assign tick   = tick_cnt_q == 16'(TICK_N - 1);
  assign per_ms = per_to_ms(act_q.period);
  assign frame  = tick && ms_q == 10'(per_ms - 10'd1);

  // divider to a one-cycle enable each millisecond
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0;
      ms_q       <= 10'h0;
    end else begin
      tick_cnt_q <= tick ? 16'h0 : 16'(tick_cnt_q + 16'h1);
      if (frame) ms_q <= 10'h0;
      else if (tick) ms_q <= 10'(ms_q + 10'd1);
      else if (ms_q >= per_ms) ms_q <= 10'h0;
    end
  end

  // ------------------------------------------------------------
  // unit conversion and output sequence
  // ------------------------------------------------------------
  isbt_bcd_if  cv ();
  isbt_state_t st_q;
  logic [26:0] prod_q;
  logic [16:0] conv;
  logic [9:0]  fac;
  logic        neg_q;
  logic [19:0] bcd_q;
  logic        pol_q;
  logic        busy_n_q;
  logic [15:0] win_q;

  function automatic logic [9:0] unit_fac(input logic [2:0] u);
    case (u)
      UNIT_N:   unit_fac = FAC_N;
      UNIT_LB:  unit_fac = FAC_LB;
      UNIT_BAR: unit_fac = FAC_BAR;
      UNIT_MPA: unit_fac = FAC_MPA;
      default:  unit_fac = FAC_ONE;
    endcase
  endfunction

  // newtons and pounds scale by hundredths, others by thousandths
  assign fac  = unit_fac(act_q.unit);
  assign conv = (act_q.unit == UNIT_N || act_q.unit == UNIT_LB) ?
                17'(prod_q / 27'd100) : 17'(prod_q / 27'd1000);
  assign cv.bin   = conv;
  // one start pulse only, so the converter never reruns during readout
  assign cv.start = st_q == ISBT_MUL;

  isbt_bcd_conv u_conv (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (cv.slave)
  );

  // sample, scale, convert, then open a busy-low read window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= ISBT_IDLE;
      prod_q   <= 27'h0;
      neg_q    <= 1'b0;
      bcd_q    <= 20'h0;
      pol_q    <= 1'b1;
      busy_n_q <= 1'b1;
      win_q    <= 16'h0;
    end else begin
      case (st_q)
        ISBT_IDLE: if (frame) begin
          prod_q   <= 27'(weight_kg * fac);
          neg_q    <= weight_neg;
          busy_n_q <= 1'b1; // data changing, not readable
          st_q     <= ISBT_MUL;
        end
        ISBT_MUL:  st_q <= ISBT_CONV;
        ISBT_CONV: if (cv.done) begin
          bcd_q    <= ~cv.bcd; // negative logic data
          pol_q    <= !neg_q;
          busy_n_q <= 1'b0; // read window opens
          win_q    <= 16'(TICK_N * BUSY_MS);
          st_q     <= ISBT_OUT;
        end
        ISBT_OUT: begin
          win_q <= 16'(win_q - 16'h1);
          if (win_q == 16'h1) begin
            busy_n_q <= 1'b1;
            st_q     <= ISBT_IDLE;
          end
        end
        default: st_q <= ISBT_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register read port, data valid one cycle after strobe
  // ------------------------------------------------------------
  logic [15:0] rsel;
  logic [15:0] rdata_q;
  assign rsel = (addr == A_UNIT) ? {13'h0, act_q.unit} :
                (addr == A_KEYS) ? {12'h0, act_q.keymask} :
                (addr == A_PER)  ? {13'h0, act_q.period} :
                (addr == A_STAT) ? {14'h0, refused_q, lock_q} :
                (addr == A_CAL)  ? cal_q[15:0] : 16'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 16'h0;
    else rdata_q <= rd ? rsel : 16'h0;
  end

  assign rdata     = rdata_q;
  assign key_act   = key_act_q;
  assign bcd_n     = bcd_q;
  assign pol_out   = pol_q;
  assign busy_n    = busy_n_q;
  assign cal_store = cal_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_reset_defaults : assert property (@(posedge clk)
    $rose(rst_n) |-> act_q.unit == UNIT_KG && act_q.keymask == 4'h0
                     && act_q.period == PER_100)
    else $error("settings not at standard values after reset");
  a_mask_blocks : assert property (@(posedge clk)
    disable iff (!rst_n) act_q.keymask[KEY_ZERO]
      && $past(act_q.keymask[KEY_ZERO]) |-> !key_act_q[KEY_ZERO])
    else $error("locked zero key acted");
  a_hold_position : assert property (@(posedge clk)
    disable iff (!rst_n)
    (k2_q[KEY_HOLD] && !k3_q[KEY_HOLD] && !act_q.keymask[KEY_HOLD])
      |=> key_act_q[KEY_HOLD])
    else $error("free hold key press lost");
  a_backup_copy : assert property (@(posedge clk)
    disable iff (!rst_n)
    do_backup |=> save_q == $past(act_q) && act_q == $past(act_q))
    else $error("backup did not copy settings");
  a_restore_load : assert property (@(posedge clk)
    disable iff (!rst_n) do_restore |=> act_q == $past(save_q))
    else $error("restore did not load image");
  a_lock_refuse : assert property (@(posedge clk)
    disable iff (!rst_n) lock_q && wr_cmd && wdata[0]
      |=> save_q == $past(save_q) && refused_q)
    else $error("backup taken while locked");
  a_period_legal : assert property (@(posedge clk)
    disable iff (!rst_n) act_q.period <= PER_1000)
    else $error("illegal bcd period held");
  a_busy_window : assert property (@(posedge clk)
    disable iff (!rst_n)
    $fell(busy_n_q) |-> bcd_q == ~$past(cv.bcd) ##1 !busy_n_q[*8])
    else $error("busy window wrong");
  a_unit_one : assert property (@(posedge clk)
    disable iff (!rst_n) st_q == ISBT_IDLE && frame && act_q.unit == UNIT_KG
      |=> prod_q == 27'($past(weight_kg) * 27'd1000))
    else $error("kg unit not unity");
  c_backup   : cover property (@(posedge clk) do_backup);
  c_restore  : cover property (@(posedge clk) do_restore);
  c_refused  : cover property (@(posedge clk) $rose(refused_q));
  c_readout  : cover property (@(posedge clk) $fell(busy_n_q));
endmodule
`default_nettype wire

//--- design/isbt_pkg.sv
// package of constants and types for the indicator settings and bcd timing
package isbt_pkg;
  // unit selection codes
  localparam logic [2:0] UNIT_KG   = 3'h0;
  localparam logic [2:0] UNIT_N    = 3'h1;
  localparam logic [2:0] UNIT_LB   = 3'h2;
  localparam logic [2:0] UNIT_BAR  = 3'h3;
  localparam logic [2:0] UNIT_MPA  = 3'h4;
  localparam logic [2:0] UNIT_RST  = 3'h0;
  // conversion factors as value*num/1000, newtons and pounds as value*num/100
  localparam logic [9:0] FAC_N     = 10'h3d4; // 9.8
  localparam logic [9:0] FAC_LB    = 10'h0dc; // 2.2 (220/100)
  localparam logic [9:0] FAC_BAR   = 10'h3d4; // 0.98 (980/1000)
  localparam logic [9:0] FAC_MPA   = 10'h062; // 0.098 (98/1000)
  localparam logic [9:0] FAC_ONE   = 10'h3e8; // 1000/1000
  // key mask bit positions, hold rightmost, zero leftmost
  localparam int KEY_HOLD = 0;
  localparam int KEY_HI   = 1;
  localparam int KEY_LO   = 2;
  localparam int KEY_ZERO = 3;
  localparam logic [3:0] KEYMASK_RST = 4'h0;
  // bcd period choices
  localparam logic [2:0] PER_10    = 3'h0;
  localparam logic [2:0] PER_20    = 3'h1;
  localparam logic [2:0] PER_50    = 3'h2;
  localparam logic [2:0] PER_100   = 3'h3;
  localparam logic [2:0] PER_200   = 3'h4;
  localparam logic [2:0] PER_500   = 3'h5;
  localparam logic [2:0] PER_1000  = 3'h6;
  localparam logic [2:0] PER_RST   = PER_100;
  // timing: 1 ms tick at 50 MHz
  localparam int CLK_HZ       = 50000000;
  localparam int TICK_MS      = 1;
  localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int BUSY_MS      = 1; // read window width in ms
  // settings image layout
  localparam int SET_W = 10;
  typedef struct packed {
    logic [2:0] unit;
    logic [3:0] keymask;
    logic [2:0] period;
  } isbt_set_t;
  localparam isbt_set_t SET_RST = '{UNIT_RST, KEYMASK_RST, PER_RST};
  typedef enum logic [1:0] {
    ISBT_IDLE = 2'b00,
    ISBT_MUL  = 2'b01,
    ISBT_CONV = 2'b10,
    ISBT_OUT  = 2'b11
  } isbt_state_t;
endpackage

//--- design/isbt_bcd_if.sv
// interface between the top and the binary to bcd converter
`timescale 1ns/100ps
`default_nettype none
interface isbt_bcd_if;
  logic        start;
  logic [16:0] bin;
  logic        done;
  logic [19:0] bcd;
  modport master (output start, output bin, input done, input bcd);
  modport slave  (input start, input bin, output done, output bcd);
endinterface
`default_nettype wire

//--- design/isbt_bcd_conv.sv
// serial double dabble converter, 17-bit binary to five bcd digits
`timescale 1ns/100ps
`default_nettype none
module isbt_bcd_conv
  import isbt_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_n,
  isbt_bcd_if.slave    bus
);
  logic [16:0] sh_q;
  logic [19:0] acc_q;
  logic [4:0]  cnt_q;
  logic        busy_q;
  logic        done_q;
  logic [19:0] adj;

  // add three to every digit above four before each shift
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_dig
      assign adj[g*4 +: 4] = (acc_q[g*4 +: 4] > 4'h4) ?
                             4'(acc_q[g*4 +: 4] + 4'h3) : acc_q[g*4 +: 4];
    end
  endgenerate

  // ------------------------------------------------------------
  // shift engine, seventeen steps per conversion
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q   <= 17'h0;
      acc_q  <= 20'h0;
      cnt_q  <= 5'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (bus.start && !busy_q) begin
        sh_q   <= bus.bin;
        acc_q  <= 20'h0;
        cnt_q  <= 5'h11;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        acc_q <= {adj[18:0], sh_q[16]};
        sh_q  <= {sh_q[15:0], 1'b0};
        cnt_q <= 5'(cnt_q - 5'h1);
        if (cnt_q == 5'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign bus.done = done_q;
  assign bus.bcd  = acc_q;
endmodule
`default_nettype wire

//--- verif/isbt_plc_reader.sv
// parallel bcd reader model standing in for the plc at the far side
`timescale 1ns/100ps
`default_nettype none
module isbt_plc_reader (
  input  wire logic        clk,
  input  wire logic [19:0] bcd_n,
  input  wire logic        pol_out,
  input  wire logic        busy_n,
  output logic      [19:0] val,
  output logic             pol,
  output int               frames,
  output int               t_per,
  output int               t_low
);
  int   cnt_per;
  int   cnt_low;
  logic busy_q;

  // ----------------------------------------
  // frame timing and sampling
  // ----------------------------------------
  initial begin
    frames  = 0;
    t_per   = 0;
    t_low   = 0;
    cnt_per = 0;
    cnt_low = 0;
    busy_q  = 1'b1;
  end

  // sample one cycle into the low window, never while busy is high
  always @(posedge clk) begin
    busy_q  <= busy_n;
    cnt_per <= (busy_q && !busy_n) ? 1 : cnt_per + 1;
    if (busy_q && !busy_n) t_per <= cnt_per;
    if (!busy_n) cnt_low <= cnt_low + 1;
    if (!busy_n && cnt_low == 1) begin
      val    <= ~bcd_n;
      pol    <= pol_out;
      frames <= frames + 1;
    end
    if (!busy_q && busy_n) begin
      t_low   <= cnt_low;
      cnt_low <= 0;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for settings, key lock and timed bcd output
`timescale 1ns/100ps
`default_nettype none
module tb
  import isbt_pkg::*;
;
  logic        clk, arst_n, wr, rd, weight_neg, cal_req, neg;
  logic [2:0]  addr;
  logic [15:0] wdata, rdata;
  logic [3:0]  key_in, key_act;
  logic [16:0] weight_kg, cal_value, cal_store;
  logic [19:0] bcd_n, val;
  logic        pol_out, busy_n, pol, m_lock, m_ref;
  int          frames, t_per, t_low, n_errors, checks, w, e, f0, seed_v;
  int          m_unit, m_mask, m_per, s_unit, s_mask, s_per, m_cal;
  // short millisecond keeps whole frames within a brief run
  localparam int TB_TICK = 50;
  int          per_tab[7] = '{10, 20, 50, 100, 200, 500, 1000};

  isbt_top #(.TICK_N(TB_TICK)) i_isbt_top (.clk(clk), .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .key_in(key_in),
    .weight_kg(weight_kg), .weight_neg(weight_neg), .cal_req(cal_req),
    .cal_value(cal_value), .key_act(key_act), .bcd_n(bcd_n),
    .pol_out(pol_out), .busy_n(busy_n), .cal_store(cal_store));
  isbt_plc_reader i_isbt_plc_reader (.clk(clk), .bcd_n(bcd_n),
    .pol_out(pol_out), .busy_n(busy_n), .val(val), .pol(pol),
    .frames(frames), .t_per(t_per), .t_low(t_low));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // the model follows every write, locked backup and restore only flag refusal
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    case (a)
      3'h0: if (d <= 4) m_unit = d;
      3'h1: m_mask = d[3:0];
      3'h2: if (d <= 6) m_per = d;
      3'h3: begin
        if (m_lock && d[1:0] != 2'h0) m_ref = 1'b1;
        else if (d[3]) m_ref = 1'b0;
        if (!m_lock && d[0]) begin
          s_unit = m_unit;
          s_mask = m_mask;
          s_per  = m_per;
        end else if (!m_lock && d[1]) begin
          m_unit = s_unit;
          m_mask = s_mask;
          m_per  = s_per;
        end
        m_lock = d[2];
      end
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [2:0] a);
    logic [15:0] x;
    case (a)
      3'h0: x = 16'(m_unit);
      3'h1: x = 16'(m_mask);
      3'h2: x = 16'(m_per);
      3'h4: x = {14'h0, m_ref, m_lock};
      3'h5: x = 16'(m_cal);
      default: x = 16'h0;
    endcase
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, x);
  endtask

  // a key press is seen three cycles late, so watch a wider span
  task automatic key_try(input int i);
    logic [3:0] seen;
    seen = 4'h0;
    @(posedge clk);
    key_in <= 4'(1 << i);
    repeat (8) begin
      @(negedge clk);
      seen = seen | key_act;
    end
    @(posedge clk);
    key_in <= 4'h0;
    repeat (6) @(posedge clk);
    chk(seen, m_mask[i] ? 4'h0 : 4'(1 << i));
  endtask

  task automatic cal_pulse(input logic [16:0] v);
    @(posedge clk);
    cal_value <= v;
    cal_req   <= 1'b1;
    repeat (8) @(posedge clk);
    cal_req <= 1'b0;
    repeat (8) @(posedge clk);
    if (!m_lock) m_cal = v;
    chk(cal_store, 32'(m_cal));
  endtask

  function automatic logic [19:0] to_bcd(input int v);
    logic [19:0] r;
    r = 20'h0;
    for (int k = 0; k < 5; k++) begin
      r[k*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // all tests need well under six thousand cycles, allow a wide margin
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    {arst_n, wr, rd, weight_neg, cal_req, m_lock, m_ref} = 7'h0;
    {addr, wdata, key_in, weight_kg, cal_value} = 57'h0;
    {m_unit, m_mask, m_per, m_cal} = {32'd0, 32'd0, 32'(PER_100), 32'd0};
    seed_v = $urandom(32'ha7bb);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 8; a++) rd_chk(3'(a));
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(3'h0, 16'(i));
      wr_reg(3'h2, 16'(i));
      rd_chk(3'h0);
      rd_chk(3'h2);
    end
    wr_reg(3'h0, 16'h9);
    rd_chk(3'h0);
    $display("test codes done");
    wr_reg(3'h0, 16'h2);
    wr_reg(3'h1, 16'h9);
    wr_reg(3'h2, 16'h0);
    wr_reg(3'h3, 16'h1);
    for (int a = 0; a < 3; a++) rd_chk(3'(a));
    wr_reg(3'h0, 16'h4);
    wr_reg(3'h1, 16'h5);
    wr_reg(3'h2, 16'h6);
    wr_reg(3'h3, 16'h2);
    for (int a = 0; a < 3; a++) rd_chk(3'(a));
    $display("test backup done");
    for (int i = 0; i < 4; i++) key_try(i);
    wr_reg(3'h1, 16'($urandom_range(0, 15)));
    for (int i = 0; i < 4; i++) key_try(i);
    $display("test keys done");
    cal_pulse(17'h1234);
    rd_chk(3'h5);
    wr_reg(3'h3, 16'h4);
    wr_reg(3'h0, 16'h3);
    wr_reg(3'h3, 16'h5);
    wr_reg(3'h0, 16'h1);
    wr_reg(3'h3, 16'h6);
    rd_chk(3'h4);
    rd_chk(3'h0);
    cal_pulse(17'h0abc);
    wr_reg(3'h3, 16'h8);
    rd_chk(3'h4);
    wr_reg(3'h3, 16'h2);
    rd_chk(3'h0);
    wr_reg(3'h0, 16'h3);
    wr_reg(3'h3, 16'h3);
    wr_reg(3'h0, 16'h1);
    wr_reg(3'h3, 16'h2);
    rd_chk(3'h0);
    $display("test lock done");
    for (int u = 0; u < 5; u++) begin
      wr_reg(3'h0, 16'(u));
      w   = $urandom_range(1, 9999);
      neg = 1'($urandom_range(0, 1));
      @(posedge clk);
      weight_kg  <= 17'(w);
      weight_neg <= neg;
      f0 = frames;
      // the second frame is the first sampled wholly after the change
      for (int k = 0; k < 2000 && frames < f0 + 2; k++) @(posedge clk);
      case (u)
        1: e = w * 98 / 10;
        2: e = w * 22 / 10;
        3: e = w * 98 / 100;
        4: e = w * 98 / 1000;
        default: e = w;
      endcase
      @(negedge clk);
      chk(frames, f0 + 2);
      chk(val, to_bcd(e % 100000));
      chk(pol, !neg);
      chk(t_low, TB_TICK * BUSY_MS);
      chk(t_per, per_tab[m_per] * TB_TICK);
    end
    $display("test bcd frames done");
    wrap_up();
  end
endmodule
`default_nettype wire
